// file: logic/usb_endpoint_ram_dma.v
// block-copy engine between data RAM and endpoint buffer RAM, with APB registers
`timescale 1ns/1ps
`default_nettype none
`include "usb_endpoint_ram_dma_regs.vh"
module usb_endpoint_ram_dma (
  // clock and reset
  input  wire        core_clk,
  input  wire        rst_n,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [9:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // module status and interrupt side
  input  wire        usbEnable,
  input  wire        usbIntEnable,
  input  wire        secViolationMask,
  output reg         usbIrq,
  output reg         secViolation,
  output reg         cpuStall,
  // data RAM port
  output reg  [13:0] ramAddr,
  output reg         ramRdEn,
  input  wire [7:0]  ramRdData,
  output reg         ramWrEn,
  output reg  [7:0]  ramWrData,
  // endpoint buffer RAM port
  output reg  [2:0]  epSel,
  output reg  [6:0]  epAddr,
  output reg         epRdEn,
  input  wire [7:0]  epRdData,
  output reg         epWrEn,
  output reg  [7:0]  epWrData,
  input  wire [7:0]  epBufferRelease
);
  // timing of one transfer of N bytes, counted from the launch edge:
  //   cycles 1..N      one source byte is read per cycle
  //   cycles 2..N+1    the byte read one cycle earlier is written
  //   cycle N+1        run clears at its end, the core resumes after it
  // the stall output covers cycles 1..N+1, so the core never sees a
  // half-finished copy and no register write can land mid-transfer
  // copy sequencer states
  localparam [1:0] ST_IDLE  = 2'b00;
  localparam [1:0] ST_COPY  = 2'b01;
  localparam [1:0] ST_DRAIN = 2'b10;
  localparam [1:0] ST_DONE  = 2'b11;

  // programmable state
  reg [2:0]  endpointSelect_q;     // endpoint for next transfer
  reg        transferDirection_q;  // 1 emits, 0 receives
  reg        transferErrorFlag_q;  // sticky launch error
  reg        transferRun_q;        // transfer in progress
  reg [13:0] ramBasePointer_q;     // RAM base, advanced by transfers
  reg [6:0]  transferByteCount_q;  // bytes per transfer

  // sequencer state
  reg [1:0]  state_q;    // copy phase
  reg [6:0]  nextIdx_q;  // next byte to read
  reg [6:0]  rdIdx_q;    // byte read in this cycle
  reg        rdActive_q; // a read is presented this cycle

  // bus decode
  wire [7:0] wordIdx;    // register index from byte address
  wire       hitCtrl;    // control and status selected
  wire       hitPtrLow;  // pointer low byte selected
  wire       hitPtrHigh; // pointer high byte selected
  wire       hitCount;   // byte count selected
  wire       mapped;     // any register selected
  wire       busOpen;    // registers reachable
  wire       wrAccess;   // write takes effect this edge
  wire       rdSetup;    // read setup cycle

  // launch evaluation
  wire       launchReq;  // run bit written while idle
  wire [2:0] newEps;     // endpoint carried in the same write
  wire       rangeErr;   // pointer window failure
  wire       paramErr;   // empty or out-of-range endpoint
  wire       sizeErr;    // count over buffer size
  wire       launchBad;  // any check failed
  wire       launchGood; // transfer may start
  wire       emitDone;   // emit transfer finishing
  wire [7:0] emitLoaded; // buffers holding emit data

  // only bits 9..2 select a register; a register fills the low byte of
  // its word and the upper bytes read as zero
  // index decode; bit 1..0 of the address are the byte in the word
  assign wordIdx    = paddr[9:2];
  assign hitCtrl    = (wordIdx == `IDX_CTRL_STATUS);
  assign hitPtrLow  = (wordIdx == `IDX_PTR_LOW);
  assign hitPtrHigh = (wordIdx == `IDX_PTR_HIGH);
  assign hitCount   = (wordIdx == `IDX_BYTE_COUNT);
  assign mapped     = hitCtrl | hitPtrLow | hitPtrHigh | hitCount;

  // closed while the USB module is off
  assign busOpen  = usbEnable & mapped; // RULE22
  assign wrAccess = psel & penable & pwrite & busOpen;
  assign rdSetup  = psel & ~penable & ~pwrite;

  // the slave never stretches a transfer; read data is already in
  // prdata when the access phase begins
  // zero wait states; error for closed or unmapped access
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~busOpen; // RULE22

  // the pointer and count are checked as they stand before the run
  // write, so software must program them in earlier transfers
  // launch takes the endpoint from the same write
  assign newEps     = pwdata[`EPS_MSB:`EPS_LSB];
  assign launchReq  = wrAccess & hitCtrl & pwdata[`BIT_RUN] & (state_q == ST_IDLE); // RULE12
  assign launchBad  = rangeErr | paramErr | sizeErr;
  assign launchGood = launchReq & ~launchBad;
  assign emitDone   = (state_q == ST_DONE) & transferDirection_q;

  // pointer plus byte offset within the 14-bit space
  function [13:0] addOffset;
    input [13:0] base;
    input [6:0]  off;
    begin
      addOffset = base + {7'h00, off};
    end
  endfunction

  // checks on the programmed pointer and count
  launch_check u_check (
    .basePtr        (ramBasePointer_q),
    .byteCount      (transferByteCount_q),
    .endpointSelect (newEps),
    .rangeErr       (rangeErr),
    .paramErr       (paramErr),
    .sizeErr        (sizeErr)
  );

  // emission flags guarding read-back
  emit_tracker u_emit (
    .core_clk      (core_clk),
    .rst_n         (rst_n),
    .emitDone      (emitDone),
    .emitEndpoint  (endpointSelect_q),
    .bufferRelease (epBufferRelease),
    .loaded_q      (emitLoaded)
  );

  // a run write that fails its checks still stores the endpoint and
  // direction, so the read-back shows what was attempted
  // control and status register
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      endpointSelect_q    <= `RST_EPS;
      transferDirection_q <= 1'b0;
      transferErrorFlag_q <= 1'b0;
    end else begin
      // fields are frozen while a transfer runs
      if (wrAccess && hitCtrl && (state_q == ST_IDLE)) begin // RULE14
        endpointSelect_q    <= newEps; // RULE1
        transferDirection_q <= pwdata[`BIT_DIR]; // RULE10
        transferErrorFlag_q <= pwdata[`BIT_ERR]; // RULE3
      end
      // launch verdict overrides the software value
      if (launchReq) begin
        transferErrorFlag_q <= launchBad; // RULE3 RULE4 RULE5 RULE6
      end
    end
  end

  // bus writes are ignored while a transfer runs; the core is stalled
  // then, so only a second bus master could try
  // pointer and count registers
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ramBasePointer_q    <= `RST_PTR; // RULE16
      transferByteCount_q <= `RST_BYTE_COUNT;
    end else begin
      if (state_q == ST_DONE) begin
        // last address plus one; count untouched
        ramBasePointer_q <= addOffset(ramBasePointer_q, transferByteCount_q); // RULE18 RULE20
      end else if (wrAccess && (state_q == ST_IDLE)) begin
        // a failed launch writes none of these
        if (hitPtrLow) begin // RULE9
          ramBasePointer_q[7:0] <= pwdata[7:0];
        end
        if (hitPtrHigh) begin
          ramBasePointer_q[13:8] <= pwdata[5:0]; // RULE15
        end
        if (hitCount) begin
          transferByteCount_q <= pwdata[6:0]; // RULE19
        end
      end
    end
  end

  // copy sequencer: one read per cycle, write one cycle behind
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q       <= ST_IDLE;
      transferRun_q <= 1'b0;
      nextIdx_q     <= 7'h00;
      rdIdx_q       <= 7'h00;
      rdActive_q    <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          rdActive_q <= 1'b0;
          // failed checks leave run clear and nothing moves
          if (launchGood) begin // RULE23
            transferRun_q <= 1'b1; // RULE12
            rdActive_q    <= 1'b1;
            rdIdx_q       <= 7'h00;
            nextIdx_q     <= 7'h01;
            // a single byte needs no copy phase, its write drains at once
            if (transferByteCount_q == 7'h01) begin
              state_q <= ST_DRAIN;
            end else begin
              state_q <= ST_COPY;
            end
          end
        end
        ST_COPY: begin
          // no bus access can stop this phase
          rdActive_q <= 1'b1; // RULE14
          rdIdx_q    <= nextIdx_q;
          nextIdx_q  <= nextIdx_q + 7'h01;
          if (nextIdx_q == (transferByteCount_q - 7'h01)) begin
            state_q <= ST_DRAIN;
          end
        end
        ST_DRAIN: begin
          // last write is registered at the end of this cycle and goes out in the next
          rdActive_q <= 1'b0;
          state_q    <= ST_DONE;
        end
        ST_DONE: begin
          // run clears after N plus one stall cycles
          transferRun_q <= 1'b0; // RULE12 RULE21
          state_q       <= ST_IDLE;
        end
        default: begin
          state_q       <= ST_IDLE;
          transferRun_q <= 1'b0;
          rdActive_q    <= 1'b0;
        end
      endcase
    end
  end

  // memory-side strobes, addresses and data
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ramAddr   <= `RST_PTR;
      ramRdEn   <= 1'b0;
      ramWrEn   <= 1'b0;
      ramWrData <= 8'h00;
      epSel     <= 3'h0;
      epAddr    <= 7'h00;
      epRdEn    <= 1'b0;
      epWrEn    <= 1'b0;
      epWrData  <= 8'h00;
    end else begin
      ramRdEn <= 1'b0;
      ramWrEn <= 1'b0;
      epRdEn  <= 1'b0;
      epWrEn  <= 1'b0;
      // read and write stages use different address ports in each
      // direction, so a read and the previous byte's write never clash
      // read stage for the byte chosen by the sequencer
      if (launchGood || (state_q == ST_COPY)) begin
        if (launchGood) begin
          epSel <= newEps;
        end
        if (launchGood ? pwdata[`BIT_DIR] : transferDirection_q) begin // RULE10
          ramRdEn <= 1'b1;
          // base is the source when emitting
          ramAddr <= addOffset(ramBasePointer_q, launchGood ? 7'h00 : nextIdx_q); // RULE17
        end else begin
          epRdEn <= 1'b1;
          epAddr <= launchGood ? 7'h00 : nextIdx_q;
        end
      end
      // read data arrives combinationally, so it is captured here
      // write stage for the byte read in the previous cycle
      if (rdActive_q) begin
        if (transferDirection_q) begin
          epWrEn   <= 1'b1;
          epAddr   <= rdIdx_q;
          epWrData <= ramRdData;
        end else begin
          ramWrEn   <= 1'b1;
          // base is the destination when receiving
          ramAddr   <= addOffset(ramBasePointer_q, rdIdx_q); // RULE17
          // buffer holding emit data reads back as zero
          ramWrData <= emitLoaded[endpointSelect_q] ? 8'h00 : epRdData; // RULE11
        end
      end
    end
  end

  // all three outputs are registered so the core and the interrupt
  // controller see glitch-free levels one cycle after the cause
  // stall, interrupt and violation outputs
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpuStall     <= 1'b0;
      usbIrq       <= 1'b0;
      secViolation <= 1'b0;
    end else begin
      // core held from launch until run clears
      cpuStall     <= launchGood | (transferRun_q & (state_q != ST_DONE)); // RULE13
      // level request while the flag stands
      usbIrq       <= transferErrorFlag_q & usbIntEnable; // RULE7
      // one-cycle security pulse on a launch failing its range or parameter check
      secViolation <= launchReq & (rangeErr | paramErr) & ~secViolationMask; // RULE8 RULE2
    end
  end

  // capturing in the setup cycle lets the access phase finish with
  // no wait state; a closed module reads back as zero
  // read data captured in the setup cycle
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
    end else if (rdSetup) begin
      prdata <= 32'h00000000;
      if (usbEnable) begin
        if (hitCtrl) begin
          prdata[`EPS_MSB:`EPS_LSB] <= endpointSelect_q;
          prdata[`BIT_ERR]          <= transferErrorFlag_q;
          prdata[`BIT_DIR]          <= transferDirection_q;
          prdata[`BIT_RUN]          <= transferRun_q;
        end else if (hitPtrLow) begin
          prdata[7:0] <= ramBasePointer_q[7:0];
        end else if (hitPtrHigh) begin
          // upper two bits stay zero
          prdata[5:0] <= ramBasePointer_q[13:8]; // RULE15
        end else if (hitCount) begin
          // reserved top bit stays zero
          prdata[6:0] <= transferByteCount_q; // RULE19
        end
      end
    end
  end
endmodule // usb_endpoint_ram_dma
`default_nettype wire

// file: logic/usb_endpoint_ram_dma_regs.vh
// register indices, field positions, reset values and limits of the endpoint copy engine
// Operation
// RULE1 - three-bit field picks endpoint and its size
// RULE2 - zero count or endpoint above four violates
// RULE3 - good launch clears error; software may clear
// RULE4 - base outside RAM window sets error
// RULE5 - base plus count past window sets error
// RULE6 - count above endpoint size sets error
// RULE7 - error flag with enable requests USB interrupt
// RULE8 - range error raises unmasked security violation
// RULE9 - failed launch leaves pointer and count unchanged
// RULE10 - direction zero receives, one emits
// RULE11 - emitted buffer data cannot be read back
// RULE12 - software sets run, engine clears at end
// RULE13 - run stalls core for whole transfer
// RULE14 - transfer runs to completion uninterrupted
// RULE15 - fourteen-bit pointer, top two bits zero
// RULE16 - pointer resets to window start
// RULE17 - pointer is RAM source or destination
// RULE18 - pointer ends at last address plus one
// RULE19 - seven-bit count, top bit reads zero
// RULE20 - count kept after transfer
// RULE21 - N bytes finish within N plus one cycles
// RULE22 - registers closed while USB disabled
// RULE23 - failed check moves nothing, releases core
`ifndef USB_ENDPOINT_RAM_DMA_REGS_VH
`define USB_ENDPOINT_RAM_DMA_REGS_VH

// register indices; byte address is four times the index
`define IDX_CTRL_STATUS 8'hEA
`define IDX_PTR_LOW     8'hEB
`define IDX_PTR_HIGH    8'hEC
`define IDX_BYTE_COUNT  8'hED

// control and status fields
`define BIT_RUN     0
`define BIT_DIR     1
`define BIT_ERR     2
`define EPS_LSB     4
`define EPS_MSB     6

// reset values
`define RST_CTRL_STATUS 8'h00
`define RST_EPS         3'h0
`define RST_PTR         14'h0100
`define RST_BYTE_COUNT  7'h00

// permitted RAM window and endpoint limits
`define WIN_LOW         14'h0100
`define WIN_HIGH        14'h10FF
`define EP_MAX_SEL      3'h4
`define EP0_SIZE        8'h40
`define EP_BIG_SIZE     8'h80
`define EP_SMALL_SIZE   8'h08

`endif

// file: logic/launch_check.v
// launch-time checks on pointer, count and endpoint
`timescale 1ns/1ps
`default_nettype none
`include "usb_endpoint_ram_dma_regs.vh"
module launch_check (
  // requested transfer
  input  wire [13:0] basePtr,
  input  wire [6:0]  byteCount,
  input  wire [2:0]  endpointSelect,
  // verdicts
  output wire        rangeErr,
  output wire        paramErr,
  output wire        sizeErr
);
  // buffer size of an endpoint in bytes
  function [7:0] epSize;
    input [2:0] ep;
    begin
      if (ep == 3'h0) begin
        epSize = `EP0_SIZE;
      end else if (ep < 3'h4) begin
        epSize = `EP_BIG_SIZE;
      end else begin
        epSize = `EP_SMALL_SIZE;
      end
    end
  endfunction

  wire [14:0] lastAddr;  // last byte touched, one bit wider against wrap
  assign lastAddr = {1'b0, basePtr} + {8'h00, byteCount} - 15'h0001;

  // base outside window, or run past its end
  assign rangeErr = (basePtr < `WIN_LOW) || (basePtr > `WIN_HIGH) ||  // RULE4
                    (lastAddr > {1'b0, `WIN_HIGH});                   // RULE5
  // empty transfer or endpoint above four
  assign paramErr = (byteCount == 7'h00) || (endpointSelect > `EP_MAX_SEL); // RULE2
  // count larger than the chosen buffer
  assign sizeErr  = ({1'b0, byteCount} > epSize(endpointSelect)); // RULE6 RULE1
endmodule // launch_check
`default_nettype wire

// file: logic/emit_tracker.v
// per-endpoint flags marking buffers loaded for emission
`timescale 1ns/1ps
`default_nettype none
module emit_tracker (
  // clock and reset
  input  wire       core_clk,
  input  wire       rst_n,
  // events
  input  wire       emitDone,
  input  wire [2:0] emitEndpoint,
  input  wire [7:0] bufferRelease,
  // state
  output reg  [7:0] loaded_q
);
  reg [7:0] loaded_d;  // next flag values

  // a finished emit sets, the protocol engine releases; set wins
  always @* begin
    loaded_d = loaded_q & ~bufferRelease;
    if (emitDone) begin
      loaded_d[emitEndpoint] = 1'b1;
    end
  end

  // flag storage
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      loaded_q <= 8'h00;
    end else begin
      loaded_q <= loaded_d;
    end
  end
endmodule // emit_tracker
`default_nettype wire

// file: tb/usb_endpoint_ram_dma_properties.sv
// port-level assertions for the endpoint copy engine
`timescale 1ns/1ps
`default_nettype none
module usb_endpoint_ram_dma_properties (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rst_n,
  // bus and status
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pslverr,
  input wire logic        usbEnable,
  input wire logic        usbIntEnable,
  input wire logic        secViolationMask,
  input wire logic        usbIrq,
  input wire logic        secViolation,
  input wire logic        cpuStall,
  // memory strobes
  input wire logic [13:0] ramAddr,
  input wire logic        ramRdEn,
  input wire logic        ramWrEn,
  input wire logic [6:0]  epAddr,
  input wire logic        epRdEn,
  input wire logic        epWrEn
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] stallCnt_q; // stall cycles already spent in this run
  // count consecutive stall cycles
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      stallCnt_q <= 8'h00;
    else
      stallCnt_q <= cpuStall ? stallCnt_q + 8'h01 : 8'h00;
  end
  a_stall_bound: assert property (cpuStall |-> stallCnt_q < 8'h80)
    else $error("core held longer than the longest transfer");
  a_irq_enable: assert property (usbIrq |-> $past(usbIntEnable))
    else $error("interrupt request while interrupts disabled");
  a_sec_pulse: assert property (secViolation |=> !secViolation)
    else $error("violation lasts more than one cycle");
  a_sec_masked: assert property (secViolation |-> !$past(secViolationMask))
    else $error("violation raised while masked");
  a_fail_quiet: assert property (secViolation |-> !cpuStall && !ramRdEn && !ramWrEn
    && !epRdEn && !epWrEn)
    else $error("failed launch moved data or held the core");
  a_strobe_stall: assert property ((ramRdEn || ramWrEn || epRdEn || epWrEn) |-> cpuStall)
    else $error("memory strobe without core stall");
  a_emit_pair: assert property (ramRdEn |=> epWrEn)
    else $error("RAM read not followed by buffer write");
  a_recv_pair: assert property (epRdEn |=> ramWrEn)
    else $error("buffer read not followed by RAM write");
  a_ram_window: assert property ((ramRdEn || ramWrEn) |-> ramAddr inside {[14'h0100:14'h10FF]})
    else $error("RAM access outside the permitted window");
  a_ram_ascend: assert property (ramRdEn && $past(ramRdEn) |-> ramAddr == $past(ramAddr) + 14'h0001)
    else $error("RAM source address not ascending");
  a_buf_ascend: assert property (epWrEn && $past(epWrEn) |-> epAddr == $past(epAddr) + 7'h01)
    else $error("buffer offset not ascending");
  a_closed_err: assert property (psel && penable && !usbEnable |-> pslverr)
    else $error("register access while module disabled");
endmodule // usb_endpoint_ram_dma_properties

bind usb_endpoint_ram_dma usb_endpoint_ram_dma_properties u_props (.core_clk, .rst_n, .psel,
  .penable, .pslverr, .usbEnable, .usbIntEnable, .secViolationMask, .usbIrq, .secViolation,
  .cpuStall, .ramAddr, .ramRdEn, .ramWrEn, .epAddr, .epRdEn, .epWrEn);
`default_nettype wire

// file: tb/usb_dma_mem_model.sv
// data RAM and endpoint buffer RAM facing the copy engine
`timescale 1ns/1ps
`default_nettype none
module usb_dma_mem_model (
  // clock
  input  wire logic        core_clk,
  // data RAM port
  input  wire logic [13:0] ramAddr,
  input  wire logic        ramRdEn,
  output wire logic [7:0]  ramRdData,
  input  wire logic        ramWrEn,
  input  wire logic [7:0]  ramWrData,
  // endpoint buffer port
  input  wire logic [2:0]  epSel,
  input  wire logic [6:0]  epAddr,
  input  wire logic        epRdEn,
  output wire logic [7:0]  epRdData,
  input  wire logic        epWrEn,
  input  wire logic [7:0]  epWrData
);
  logic [7:0] ramMem [0:16383];  // whole data RAM
  logic [7:0] epMem  [0:1023];   // eight buffers of 128 bytes, endpoint then offset
  logic [7:0] junk_q = 8'h5A;    // filler that moves every cycle when not read
  // read data only while asked for, junk otherwise
  assign ramRdData = ramRdEn ? ramMem[ramAddr] : junk_q;
  assign epRdData  = epRdEn ? epMem[{epSel, epAddr}] : ~junk_q;
  // writes land at the clock edge
  always @(posedge core_clk) begin
    junk_q <= ~junk_q + 8'h01;
    if (ramWrEn) ramMem[ramAddr] <= ramWrData;
    if (epWrEn) epMem[{epSel, epAddr}] <= epWrData;
  end
endmodule // usb_dma_mem_model
`default_nettype wire

// file: tb/usb_endpoint_ram_dma_tb.sv
// self-checking bench for the endpoint copy engine
`timescale 1ns/1ps
`default_nettype none
`include "usb_endpoint_ram_dma_regs.vh"
module usb_endpoint_ram_dma_tb;
  localparam logic [9:0] addrCs = {`IDX_CTRL_STATUS, 2'b00};
  localparam logic [9:0] addrPl = {`IDX_PTR_LOW, 2'b00};
  localparam logic [9:0] addrPh = {`IDX_PTR_HIGH, 2'b00};
  localparam logic [9:0] addrBc = {`IDX_BYTE_COUNT, 2'b00};
  logic        core_clk, rst_n, psel, penable, pwrite, usbEnable, usbIntEnable, secViolationMask;
  logic [9:0]  paddr;
  logic [31:0] pwdata, rd;
  logic [7:0]  epBufferRelease;
  logic        rdErr;
  wire  [31:0] prdata;
  wire         pready, pslverr, usbIrq, secViolation, cpuStall, ramRdEn, ramWrEn, epRdEn, epWrEn;
  wire  [13:0] ramAddr;
  wire  [7:0]  ramRdData, ramWrData, epRdData, epWrData;
  wire  [2:0]  epSel;
  wire  [6:0]  epAddr;
  int          error_cnt = 0, checked = 0, stallCycles = 0, secCnt = 0;
  usb_endpoint_ram_dma u_dut (.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .usbEnable, .usbIntEnable, .secViolationMask, .usbIrq,
    .secViolation, .cpuStall, .ramAddr, .ramRdEn, .ramRdData, .ramWrEn, .ramWrData, .epSel,
    .epAddr, .epRdEn, .epRdData, .epWrEn, .epWrData, .epBufferRelease);
  usb_dma_mem_model u_mem (.core_clk, .ramAddr, .ramRdEn, .ramRdData, .ramWrEn, .ramWrData,
    .epSel, .epAddr, .epRdEn, .epRdData, .epWrEn, .epWrData);
  // clock
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // count stall cycles and violation pulses
  always @(posedge core_clk) begin
    if (cpuStall === 1'b1) stallCycles <= stallCycles + 1;
    if (secViolation === 1'b1) secCnt <= secCnt + 1;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask
  // one APB transfer, held until pready
  task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd    = prdata;
    rdErr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // program, launch, wait for the core to resume, then check registers
  task automatic launch(input logic [13:0] p, input logic [6:0] c, input logic [2:0] ep,
                        input logic dir, input logic mask, input logic bad, input logic sec);
    int s0, v0;
    logic [7:0] pl;
    logic [13:0] expP;
    expP = bad ? p : p + {7'h00, c};
    secViolationMask <= mask;
    apb(1'b1, addrPl, {24'h0, p[7:0]});
    apb(1'b1, addrPh, {26'h0, p[13:8]});
    apb(1'b1, addrBc, {25'h0, c});
    s0 = stallCycles;
    v0 = secCnt;
    apb(1'b1, addrCs, {25'h0, ep, 2'b00, dir, 1'b1});
    do @(posedge core_clk); while (cpuStall !== 1'b0);
    @(posedge core_clk);
    chk(stallCycles - s0, bad ? 0 : c + 1, "stall cycles");
    chk(secCnt - v0, sec, "violation pulses");
    apb(1'b0, addrCs, 0);
    chk(rd, {25'h0, ep, 1'b0, bad, dir, 1'b0}, "control status");
    apb(1'b0, addrPl, 0);
    pl = rd[7:0];
    apb(1'b0, addrPh, 0);
    chk({rd[23:0], pl}, {18'h0, expP}, "pointer");
    apb(1'b0, addrBc, 0);
    chk(rd, {25'h0, c}, "byte count");
    chk(usbIrq, bad, "usb interrupt");
  endtask
  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (20000) @(posedge core_clk);
    $display("unexpected at %0t: run did not finish", $time);
    error_cnt++;
    summarize();
  end
  // main sequence
  initial begin
    rst_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {usbEnable, usbIntEnable, secViolationMask, epBufferRelease} = {2'b11, 9'h000};
    for (int k = 0; k < 64; k++) u_mem.ramMem[14'h0100 + k] = 8'h30 + k[7:0];
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, {`IDX_CTRL_STATUS + i[7:0], 2'b00}, 0);
      chk(rd, (i == 2) ? 32'h1 : 32'h0, "reset value");
    end
    apb(1'b0, {8'hEE, 2'b00}, 0);
    chk(rdErr, 1'b1, "unmapped access");
    apb(1'b1, addrPh, 32'hFF);
    apb(1'b0, addrPh, 0);
    chk(rd, 32'h3F, "pointer high reserved bits");
    apb(1'b1, addrBc, 32'hFF);
    apb(1'b0, addrBc, 0);
    chk(rd, 32'h7F, "count reserved bit");
    usbEnable <= 1'b0;
    apb(1'b1, addrPl, 32'h55);
    chk(rdErr, 1'b1, "closed write");
    usbEnable <= 1'b1;
    apb(1'b0, addrPl, 0);
    chk(rd, 32'h0, "closed write ignored");
    launch(14'h0100, 7'd64, 3'd0, 1'b1, 1'b0, 1'b0, 1'b0);
    for (int k = 0; k < 64; k++) chk(u_mem.epMem[k], 8'h30 + k[7:0], "emitted byte");
    launch(14'h0200, 7'd4, 3'd0, 1'b0, 1'b0, 1'b0, 1'b0);
    for (int k = 0; k < 4; k++) chk(u_mem.ramMem[14'h0200 + k], 8'h00, "read back");
    epBufferRelease <= 8'h01;
    @(posedge core_clk);
    epBufferRelease <= 8'h00;
    launch(14'h0300, 7'd4, 3'd0, 1'b0, 1'b0, 1'b0, 1'b0);
    for (int k = 0; k < 4; k++) chk(u_mem.ramMem[14'h0300 + k], 8'h30 + k[7:0], "rx");
    launch(14'h0100, 7'd0, 3'd0, 1'b1, 1'b0, 1'b1, 1'b1);
    launch(14'h0100, 7'd8, 3'd4, 1'b1, 1'b0, 1'b0, 1'b0);
    launch(14'h0100, 7'd4, 3'd5, 1'b1, 1'b0, 1'b1, 1'b1);
    launch(14'h0100, 7'd4, 3'd7, 1'b1, 1'b1, 1'b1, 1'b0);
    launch(14'h00FF, 7'd1, 3'd0, 1'b1, 1'b0, 1'b1, 1'b1);
    launch(14'h10FC, 7'd4, 3'd0, 1'b1, 1'b0, 1'b0, 1'b0);
    launch(14'h10FD, 7'd4, 3'd0, 1'b1, 1'b0, 1'b1, 1'b1);
    launch(14'h0100, 7'd127, 3'd1, 1'b1, 1'b0, 1'b0, 1'b0);
    launch(14'h0100, 7'd65, 3'd0, 1'b1, 1'b0, 1'b1, 1'b0);
    launch(14'h0100, 7'd9, 3'd4, 1'b1, 1'b0, 1'b1, 1'b0);
    usbIntEnable <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk(usbIrq, 1'b0, "interrupt disabled");
    usbIntEnable <= 1'b1;
    apb(1'b1, addrCs, 0);
    apb(1'b0, addrCs, 0);
    chk(rd, 32'h0, "software clear");
    chk(usbIrq, 1'b0, "interrupt after clear");
    summarize();
  end
endmodule // usb_endpoint_ram_dma_tb
`default_nettype wire
